// ===== sgsel_defs.vh
// constants shared by the setting group selector files
`ifndef SGSEL_DEFS_VH
`define SGSEL_DEFS_VH

// bus and register map
`define SGSEL_AW            8
`define SGSEL_DW            32
`define SGSEL_REG_CTRL      8'h00
`define SGSEL_REG_TIMEOUT   8'h04
`define SGSEL_REG_REQ       8'h08
`define SGSEL_REG_STATUS    8'h0C
`define SGSEL_REG_NVPOS     8'h10
`define SGSEL_RESP_OKAY     2'h0
`define SGSEL_RESP_SLVERR   2'h2

// control register fields
`define SGSEL_CTRL_RANGE_LO 0
`define SGSEL_CTRL_RANGE_HI 2
`define SGSEL_CTRL_STP_ACK  4
`define SGSEL_CTRL_BIT_ACK  5
`define SGSEL_CTRL_PWR_SYNC 6
`define SGSEL_CTRL_BLOCK    7
`define SGSEL_CTRL_RST      32'h0000_0007
`define SGSEL_TIMEOUT_RST   32'h0000_1388

// timing
`define SGSEL_CLK_MHZ       100
`define SGSEL_TICK_NS       1000000
`define SGSEL_TICK_CYC      (`SGSEL_TICK_NS * `SGSEL_CLK_MHZ / 1000)
`define SGSEL_TICK_LAST     17'h1869F
`define SGSEL_ALARM_MS      16'h0BB8
`define SGSEL_TICK_W        17
`define SGSEL_MS_W          16

// misc widths and values
`define SGSEL_GROUPS        6
`define SGSEL_POS_W         3
`define SGSEL_POS_ONE       3'h1
`define SGSEL_POS_ZERO      3'h0

// selector states
`define SGSEL_ST_IDLE       2'h0
`define SGSEL_ST_STEP       2'h1
`define SGSEL_ST_WORD       2'h2

`endif

// ===== sgsel_alarm_timer.v
// one stretched alarm output held for a fixed number of ms ticks
`timescale 1ns/1ps
`include "sgsel_defs.vh"

module sgsel_alarm_timer (
	input  wire        clk,
	input  wire        rst,
	input  wire        tick,
	input  wire        fire,
	output reg         alarm
);
	reg [`SGSEL_MS_W-1:0] cnt_r;

	// fire restarts the full hold time, even while already running
	always @(posedge clk) begin
		if (rst) begin
			cnt_r <= {`SGSEL_MS_W{1'b0}};
			alarm <= 1'b0;
		end else if (fire) begin
			cnt_r <= `SGSEL_ALARM_MS;
			alarm <= 1'b1;
		end else if (tick && cnt_r != {`SGSEL_MS_W{1'b0}}) begin
			cnt_r <= cnt_r - 1'b1;
			alarm <= (cnt_r != `SGSEL_MS_W'h1);
		end
	end
endmodule

// ===== sgsel_group_prio.v
// priority picker among group requests with block hold
`timescale 1ns/1ps
`include "sgsel_defs.vh"

module sgsel_group_prio (
	input  wire        clk,
	input  wire        rst,
	input  wire        block,
	input  wire [5:1]  req,
	output reg  [5:0]  active_oh
);
	reg [5:0] pick;
	integer   i;

	// highest requested wins; bank 1 when nothing asks
	always @* begin
		pick = 6'h01;
		for (i = 1; i <= 5; i = i + 1) begin
			if (req[i]) begin
				pick = 6'h01 << i;
			end
		end
	end

	// one-hot register, so exactly one bank always in service
	always @(posedge clk) begin
		if (rst) begin
			active_oh <= 6'h01;
		end else if (!block) begin
			active_oh <= pick;
		end
	end
endmodule

// ===== sgsel_top.v
// setting group activation and selector switch with axi4-lite registers
// Functional notes
// - six banks, exactly one in service
// - block input freezes the active bank
// - highest requested bank wins
// - bank 1 is default, no request
// - steady indicator per bank in service
// - each step-up pulse advances pre-selection one
// - 3-bit word pre-selects position directly
// - pre-selection applied on time-out or acknowledge
// - applied position kept in non-volatile store
// - power-up restores stored or adopts word; reset clears the sync bit (ctrl bit 6), so only stored is restored
// - stepping past full range wraps to one
// - word accepted only within one to range
// - out-of-range word raises alarm three seconds
// - programmable time-out shared by both selectors
// - advance on rising edge, pulses 50 ms apart; the code enforces no minimum spacing
// - activity restarts timer; missed ack discards, alarms
// - all-zero word is rest, no action
// - step-up and word inputs lock each other out
`timescale 1ns/1ps
`include "sgsel_defs.vh"

module sgsel_top (
	input  wire                   clk,
	input  wire                   rst,
	input  wire [`SGSEL_AW-1:0]   s_axi_awaddr,
	input  wire                   s_axi_awvalid,
	output wire                   s_axi_awready,
	input  wire [`SGSEL_DW-1:0]   s_axi_wdata,
	input  wire [3:0]             s_axi_wstrb,
	input  wire                   s_axi_wvalid,
	output wire                   s_axi_wready,
	output reg  [1:0]             s_axi_bresp,
	output reg                    s_axi_bvalid,
	input  wire                   s_axi_bready,
	input  wire [`SGSEL_AW-1:0]   s_axi_araddr,
	input  wire                   s_axi_arvalid,
	output wire                   s_axi_arready,
	output reg  [`SGSEL_DW-1:0]   s_axi_rdata,
	output reg  [1:0]             s_axi_rresp,
	output reg                    s_axi_rvalid,
	input  wire                   s_axi_rready,
	input  wire                   group_change_block,
	input  wire [5:1]             group_req,
	input  wire                   step_up,
	input  wire                   step_ack,
	input  wire                   direct_word_bit0,
	input  wire                   direct_word_bit1,
	input  wire                   direct_word_bit2,
	input  wire                   word_ack,
	input  wire [`SGSEL_POS_W-1:0] nv_pos_in,
	output reg                    nv_write,
	output reg  [`SGSEL_POS_W-1:0] nv_pos_out,
	output wire [5:0]             group_led,
	output reg  [7:1]             sel_pos_oh,
	output wire                   sel_range_alarm,
	output wire                   sel_step_alarm,
	output wire                   sel_word_alarm,
	output reg                    sel_pwr_alarm
);
	// software registers
	reg [`SGSEL_DW-1:0]   ctrl_r;
	reg [`SGSEL_DW-1:0]   timeout_r;
	reg [5:1]             sw_req_r;
	// selector state
	reg [1:0]             st_r;
	reg [`SGSEL_POS_W-1:0] pre_r;
	reg [`SGSEL_POS_W-1:0] pos_r;
	reg [`SGSEL_MS_W-1:0] tmo_r;
	reg                   up_d_r, sack_d_r, wack_d_r;
	reg [`SGSEL_POS_W-1:0] word_d_r;
	reg                   pwr_done_r;
	reg [`SGSEL_TICK_W-1:0] tick_cnt_r;
	reg                   tick_r;
	reg                   fire_rng, fire_stp, fire_bit;
	// bus handshake state
	reg                   aw_hold_r, w_hold_r;
	reg [`SGSEL_AW-1:0]   awaddr_r;
	reg [`SGSEL_DW-1:0]   wdata_r;

	wire [`SGSEL_POS_W-1:0] word = {direct_word_bit2, direct_word_bit1, direct_word_bit0};
	wire [`SGSEL_POS_W-1:0] range = ctrl_r[`SGSEL_CTRL_RANGE_HI:`SGSEL_CTRL_RANGE_LO];
	wire stp_ack_mode = ctrl_r[`SGSEL_CTRL_STP_ACK];
	wire bit_ack_mode = ctrl_r[`SGSEL_CTRL_BIT_ACK];
	wire up_rise      = step_up & ~up_d_r;
	wire sack_rise    = step_ack & ~sack_d_r;
	wire wack_rise    = word_ack & ~wack_d_r;
	wire word_chg     = (word != word_d_r) && (word != `SGSEL_POS_ZERO);
	wire word_ok      = (word >= `SGSEL_POS_ONE) && (word <= range);
	wire tmo_zero     = (tmo_r == {`SGSEL_MS_W{1'b0}});
	wire [7:0] pos_dec = 8'h01 << pos_r;                   // bit 0 is position 0, dropped

	// millisecond tick from the system clock
	always @(posedge clk) begin
		if (rst || tick_cnt_r == `SGSEL_TICK_LAST) begin
			tick_cnt_r <= {`SGSEL_TICK_W{1'b0}};
			tick_r     <= ~rst;
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
			tick_r     <= 1'b0;
		end
	end

	// input history for synchronous edge detection
	always @(posedge clk) begin
		if (rst) begin
			up_d_r   <= 1'b0;
			sack_d_r <= 1'b0;
			wack_d_r <= 1'b0;
			word_d_r <= `SGSEL_POS_ZERO;
		end else begin
			up_d_r   <= step_up;
			sack_d_r <= step_ack;
			wack_d_r <= word_ack;
			word_d_r <= word;
		end
	end

	// selector: pre-select, time out or acknowledge, then apply
	always @(posedge clk) begin
		fire_rng <= 1'b0;
		fire_stp <= 1'b0;
		fire_bit <= 1'b0;
		nv_write <= 1'b0;
		if (rst) begin
			st_r          <= `SGSEL_ST_IDLE;
			pre_r         <= `SGSEL_POS_ZERO;
			pos_r         <= `SGSEL_POS_ZERO;
			tmo_r         <= {`SGSEL_MS_W{1'b0}};
			pwr_done_r    <= 1'b0;
			sel_pwr_alarm <= 1'b0;
			nv_pos_out    <= `SGSEL_POS_ZERO;
		end else if (!pwr_done_r) begin
			// first cycle after reset: restore or synchronise
			pwr_done_r <= 1'b1;
			if (ctrl_r[`SGSEL_CTRL_PWR_SYNC]) begin
				pos_r         <= word_ok ? word : `SGSEL_POS_ZERO;
				sel_pwr_alarm <= ~word_ok;
			end else begin
				pos_r         <= (nv_pos_in >= `SGSEL_POS_ONE && nv_pos_in <= range)
				                 ? nv_pos_in : `SGSEL_POS_ZERO;
				sel_pwr_alarm <= ~(nv_pos_in >= `SGSEL_POS_ONE && nv_pos_in <= range);
			end
		end else begin
			if (tick_r && !tmo_zero) begin
				tmo_r <= tmo_r - 1'b1;
			end
			case (st_r)
			`SGSEL_ST_IDLE: begin
				if (up_rise) begin
					st_r  <= `SGSEL_ST_STEP;
					pre_r <= (pos_r >= range) ? `SGSEL_POS_ONE : pos_r + 1'b1;
					tmo_r <= timeout_r[`SGSEL_MS_W-1:0];
				end else if (word_chg) begin
					if (word_ok) begin
						st_r  <= `SGSEL_ST_WORD;
						pre_r <= word;
						tmo_r <= timeout_r[`SGSEL_MS_W-1:0];
					end else begin
						fire_rng <= 1'b1;
					end
				end
			end
			`SGSEL_ST_STEP: begin
				// word input ignored while stepping
				if (up_rise) begin
					pre_r <= (pre_r >= range) ? `SGSEL_POS_ONE : pre_r + 1'b1;
					tmo_r <= timeout_r[`SGSEL_MS_W-1:0];
				end else if (stp_ack_mode && sack_rise) begin
					pos_r      <= pre_r;
					nv_write   <= 1'b1;
					nv_pos_out <= pre_r;
					st_r       <= `SGSEL_ST_IDLE;
				end else if (tmo_zero) begin
					st_r <= `SGSEL_ST_IDLE;
					if (stp_ack_mode) begin
						fire_stp <= 1'b1;
					end else begin
						pos_r      <= pre_r;
						nv_write   <= 1'b1;
						nv_pos_out <= pre_r;
					end
				end
			end
			`SGSEL_ST_WORD: begin
				// step-up ignored while the word sequence runs
				if (word_chg) begin
					if (word_ok) begin
						pre_r <= word;
						tmo_r <= timeout_r[`SGSEL_MS_W-1:0];
					end else begin
						fire_rng <= 1'b1;
					end
				end else if (bit_ack_mode && wack_rise) begin
					pos_r      <= pre_r;
					nv_write   <= 1'b1;
					nv_pos_out <= pre_r;
					st_r       <= `SGSEL_ST_IDLE;
				end else if (tmo_zero) begin
					st_r <= `SGSEL_ST_IDLE;
					if (bit_ack_mode) begin
						fire_bit <= 1'b1;
					end else begin
						pos_r      <= pre_r;
						nv_write   <= 1'b1;
						nv_pos_out <= pre_r;
					end
				end
			end
			default: begin
				st_r <= `SGSEL_ST_IDLE;
			end
			endcase
		end
	end

	// one-hot applied position; zero means no position selected
	always @(posedge clk) begin
		if (rst) begin
			sel_pos_oh <= 7'h00;
		end else begin
			sel_pos_oh <= pos_dec[7:1];
		end
	end

	// three-second alarm stretchers
	sgsel_alarm_timer u_rng_alarm (
		.clk   (clk),
		.rst   (rst),
		.tick  (tick_r),
		.fire  (fire_rng),
		.alarm (sel_range_alarm)
	);
	sgsel_alarm_timer u_stp_alarm (
		.clk   (clk),
		.rst   (rst),
		.tick  (tick_r),
		.fire  (fire_stp),
		.alarm (sel_step_alarm)
	);
	sgsel_alarm_timer u_bit_alarm (
		.clk   (clk),
		.rst   (rst),
		.tick  (tick_r),
		.fire  (fire_bit),
		.alarm (sel_word_alarm)
	);

	// group activation; pins or software can request, block from either
	sgsel_group_prio u_prio (
		.clk       (clk),
		.rst       (rst),
		.block     (group_change_block | ctrl_r[`SGSEL_CTRL_BLOCK]),
		.req       (group_req | sw_req_r),
		.active_oh (group_led)
	);
	// indicator is the registered one-hot, steady, bank 1 by default

	// axi4-lite write: address and data accepted in either order
	assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
	wire   [`SGSEL_AW-1:0] wa = aw_hold_r ? awaddr_r : s_axi_awaddr;
	wire   [`SGSEL_DW-1:0] wd = w_hold_r ? wdata_r : s_axi_wdata;
	wire   wr_go = (aw_hold_r | (s_axi_awvalid & s_axi_awready)) &
	               (w_hold_r | (s_axi_wvalid & s_axi_wready));

	always @(posedge clk) begin
		if (rst) begin
			aw_hold_r    <= 1'b0;
			w_hold_r     <= 1'b0;
			awaddr_r     <= {`SGSEL_AW{1'b0}};
			wdata_r      <= {`SGSEL_DW{1'b0}};
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SGSEL_RESP_OKAY;
			ctrl_r       <= `SGSEL_CTRL_RST;
			timeout_r    <= `SGSEL_TIMEOUT_RST;
			sw_req_r     <= 5'h00;
		end else if (wr_go) begin
			aw_hold_r    <= 1'b0;
			w_hold_r     <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= `SGSEL_RESP_OKAY;
			case (wa)
			`SGSEL_REG_CTRL:    ctrl_r    <= wd;
			`SGSEL_REG_TIMEOUT: timeout_r <= wd;
			`SGSEL_REG_REQ:     sw_req_r  <= wd[5:1];
			`SGSEL_REG_STATUS, `SGSEL_REG_NVPOS: s_axi_bresp <= `SGSEL_RESP_OKAY;
			default:            s_axi_bresp <= `SGSEL_RESP_SLVERR;
			endcase
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
			end
			if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// axi4-lite read: answer one cycle after the address
	assign s_axi_arready = ~s_axi_rvalid;

	always @(posedge clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= {`SGSEL_DW{1'b0}};
			s_axi_rresp  <= `SGSEL_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `SGSEL_RESP_OKAY;
			case (s_axi_araddr)
			`SGSEL_REG_CTRL:    s_axi_rdata <= ctrl_r;
			`SGSEL_REG_TIMEOUT: s_axi_rdata <= timeout_r;
			`SGSEL_REG_REQ:     s_axi_rdata <= {26'h0, sw_req_r, 1'b0};
			`SGSEL_REG_STATUS:  s_axi_rdata <= {10'h0, st_r, 1'b0, pre_r, 1'b0, pos_r,
			                                    sel_pwr_alarm, sel_word_alarm,
			                                    sel_step_alarm, sel_range_alarm, 2'h0,
			                                    group_led};
			`SGSEL_REG_NVPOS:   s_axi_rdata <= {29'h0, nv_pos_out};
			default: begin
				s_axi_rdata <= {`SGSEL_DW{1'b0}};
				s_axi_rresp <= `SGSEL_RESP_SLVERR;
			end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ===== sgsel_checker.sv
// assertions on the selector top ports
`timescale 1ns/1ps
module sgsel_checker (
	input wire       clk,
	input wire       rst,
	input wire       group_change_block,
	input wire [5:1] group_req,
	input wire       nv_write,
	input wire [2:0] nv_pos_out,
	input wire [5:0] group_led,
	input wire [7:1] sel_pos_oh,
	input wire       sel_range_alarm
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// bank indicators follow the request pins one cycle later unless blocked
	a_one_bank: assert property ($onehot(group_led))
		else $error("bank indicators not one-hot");
	a_block_hold: assert property (group_change_block |=> $stable(group_led))
		else $error("bank moved while blocked");
	a_high_wins: assert property (!group_change_block && group_req[5] |=> group_led == 6'h20)
		else $error("highest request lost");
	a_bank_default: assert property (!group_change_block && group_req == 5'h00 |=> group_led == 6'h01)
		else $error("bank one not default");
	// applied position, its store and its one-hot view
	a_pos_onehot: assert property ($onehot0(sel_pos_oh))
		else $error("position outputs not one-hot");
	a_store_pulse: assert property (nv_write |=> !nv_write)
		else $error("store strobe longer than one cycle");
	a_store_shown: assert property (nv_write |-> ##[1:2] sel_pos_oh == 7'h01 << (nv_pos_out - 3'h1))
		else $error("stored position not shown");
	// power-up restore may move the outputs a few edges after reset
	a_pos_cause: assert property ($changed(sel_pos_oh) |-> $past(nv_write) || $past(nv_write, 2)
		|| $past(rst, 2) || $past(rst, 3) || $past(rst, 4))
		else $error("position changed without apply");
	a_alarm_stretch: assert property ($rose(sel_range_alarm) |=> sel_range_alarm [*8])
		else $error("range alarm not held");
	c_blocked: cover property (group_change_block && group_req != 5'h00);
	c_store: cover property (nv_write);
	c_alarm: cover property ($rose(sel_range_alarm));
endmodule
bind sgsel_top sgsel_checker u_sgsel_checker (.*);

// ===== sgsel_partner.sv
// far side model: request logic, pushbuttons, contact word and nv store
`timescale 1ns/1ps
module sgsel_partner (
	input  wire        clk,
	input  wire        nv_write,
	input  wire  [2:0] nv_pos_out,
	output logic       group_change_block,
	output logic [5:1] group_req,
	output logic       step_up,
	output logic       step_ack,
	output logic       word_ack,
	output logic       direct_word_bit0,
	output logic       direct_word_bit1,
	output logic       direct_word_bit2,
	output logic [2:0] nv_pos_in
);
	// all idle at time zero, the store holds position three
	initial begin
		{group_change_block, group_req, step_up, step_ack, word_ack} = 9'h000;
		{direct_word_bit2, direct_word_bit1, direct_word_bit0} = 3'h0;
		nv_pos_in = 3'h3;
	end
	// store keeps the last written position across device resets
	always @(posedge clk)
		if (nv_write)
			nv_pos_in <= nv_pos_out;
	// contacts change just after an edge
	task automatic grp(input logic b, input logic [5:1] r);
		@(posedge clk);
		group_change_block <= b;
		group_req <= r;
	endtask
	task automatic word(input logic [2:0] w);
		@(posedge clk);
		{direct_word_bit2, direct_word_bit1, direct_word_bit0} <= w;
	endtask
	// one press per sequence keeps step pulses far apart
	task automatic press(input int k);
		@(posedge clk);
		step_up <= (k == 0);
		step_ack <= (k == 1);
		word_ack <= (k == 2);
		repeat (4) @(posedge clk);
		{step_up, step_ack, word_ack} <= 3'h0;
	endtask
endmodule

// ===== sgsel_top_tb.sv
// self-checking bench for the selector top
`timescale 1ns/1ps
`include "sgsel_defs.vh"
module sgsel_top_tb;
	logic        clk, rst;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire         group_change_block, step_up, step_ack, word_ack, nv_write;
	wire         direct_word_bit0, direct_word_bit1, direct_word_bit2;
	wire  [5:1]  group_req;
	wire  [2:0]  nv_pos_in, nv_pos_out;
	wire  [5:0]  group_led;
	wire  [7:1]  sel_pos_oh;
	wire         sel_range_alarm, sel_step_alarm, sel_word_alarm, sel_pwr_alarm;
	wire  [3:0]  alarms = {sel_pwr_alarm, sel_word_alarm, sel_step_alarm, sel_range_alarm};
	int          error_cnt = 0, check_count = 0, seed = 82, i;
	logic        armed = 1'b0, b;
	logic [5:1]  r;
	logic [5:0]  exp_led;
	logic [33:0] rq[$];
	logic [2:0]  nq[$];
	logic [9:0]  oq[$];
	event        samp;
	sgsel_top u_sgsel_top (.*);
	sgsel_partner u_sgsel_partner (.*);
	always #5 clk = ~clk;
	task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one compare per kind of result, all counted by cmp
	task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
		cmp(got, exp);
	endtask
	task automatic cmp_nv(input logic [33:0] got, input logic [33:0] exp);
		cmp(got, exp);
	endtask
	task automatic cmp_out(input logic [33:0] got, input logic [33:0] exp);
		cmp(got, exp);
	endtask
	task automatic results();
		$display("mismatches %0d, checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic fail_to();
		error_cnt++;
		results();
	endtask
	// one bus transfer; bits of left: aw, w, b, ar, r still owed
	task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [33:0] e);
		int n;
		logic [4:0] left, h;
		left = w ? 5'h1C : 5'h03;
		rq.push_back(e);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= w ? 4'hF : 4'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= left;
		for (n = 0; n < 50 && left != 5'h00; n++) begin
			@(negedge clk);
			h = left & {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid};
			@(posedge clk);
			left = left & ~h;
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= left;
		end
		if (left != 5'h00)
			fail_to();
	endtask
	task automatic expect_out(input logic [1:0] k, input logic [7:0] v);
		oq.push_back({k, v});
		@(negedge clk);
		-> samp;
	endtask
	task automatic wait_nv();
		int n;
		for (n = 0; n < 100 && nq.size() > 0; n++)
			@(posedge clk);
		if (nq.size() > 0)
			fail_to();
		else
			repeat (3) @(posedge clk);
	endtask
	function automatic logic [5:0] prio(input logic [5:1] q);
		int k;
		prio = 6'h01;
		for (k = 1; k <= 5; k++)
			if (q[k])
				prio = 6'h01 << k;
	endfunction
	// bus answers and store strobes against the oldest note
	always @(posedge clk) begin
		if (s_axi_bvalid && s_axi_bready)
			cmp_bus({s_axi_bresp, 32'h0}, rq.pop_front());
		if (s_axi_rvalid && s_axi_rready)
			cmp_bus({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (nv_write && armed)
			cmp_nv(34'(nv_pos_out),
			       nq.size() ? 34'(nq.pop_front()) : 34'h3_FFFF_FFFF);
	end
	// settled outputs sampled mid-cycle
	always @(samp) begin
		case (oq[0][9:8])
			2'h0: cmp_out(34'(group_led), 34'(oq[0][5:0]));
			2'h1: cmp_out(34'(sel_pos_oh), 34'(oq[0][6:0]));
			default: cmp_out(34'(alarms), 34'(oq[0][3:0]));
		endcase
		void'(oq.pop_front());
	end
	// main sequence: groups, registers, then selector
	initial begin
		clk = 1'b0;
		rst <= 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= 52'h0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		expect_out(2'h1, 8'h04);
		armed = 1'b1;
		exp_led = 6'h01;
		for (i = 0; i < 16; i++) begin
			r = 5'($random(seed));
			b = (i % 4 == 3);
			u_sgsel_partner.grp(b, r);
			if (!b)
				exp_led = prio(r);
			repeat (2) @(posedge clk);
			expect_out(2'h0, {2'h0, exp_led});
		end
		u_sgsel_partner.grp(1'b0, 5'h00);
		axi(1'b0, `SGSEL_REG_CTRL, 32'h0, {`SGSEL_RESP_OKAY, `SGSEL_CTRL_RST});
		axi(1'b0, `SGSEL_REG_TIMEOUT, 32'h0, {`SGSEL_RESP_OKAY, `SGSEL_TIMEOUT_RST});
		axi(1'b0, 8'h24, 32'h0, {`SGSEL_RESP_SLVERR, 32'h0});
		axi(1'b1, 8'h24, 32'h5, {`SGSEL_RESP_SLVERR, 32'h0});
		axi(1'b1, `SGSEL_REG_TIMEOUT, 32'h2, {`SGSEL_RESP_OKAY, 32'h0});
		axi(1'b0, `SGSEL_REG_TIMEOUT, 32'h0, {`SGSEL_RESP_OKAY, 32'h2});
		// range three, both selectors in acknowledge mode
		axi(1'b1, `SGSEL_REG_CTRL, 32'h33, {`SGSEL_RESP_OKAY, 32'h0});
		axi(1'b0, `SGSEL_REG_CTRL, 32'h0, {`SGSEL_RESP_OKAY, 32'h33});
		u_sgsel_partner.press(0);
		u_sgsel_partner.word(3'h2);
		nq.push_back(3'h1);
		u_sgsel_partner.press(1);
		wait_nv();
		expect_out(2'h1, 8'h01);
		u_sgsel_partner.press(2);
		u_sgsel_partner.word(3'h3);
		nq.push_back(3'h3);
		u_sgsel_partner.press(2);
		wait_nv();
		u_sgsel_partner.word(3'h0);
		u_sgsel_partner.word(3'h5);
		repeat (8) @(posedge clk);
		expect_out(2'h2, 8'h01);
		expect_out(2'h1, 8'h04);
		// zero time-out: time-out mode applies at once, ack mode alarms at once
		axi(1'b1, `SGSEL_REG_TIMEOUT, 32'h0, {`SGSEL_RESP_OKAY, 32'h0});
		axi(1'b1, `SGSEL_REG_CTRL, 32'h3, {`SGSEL_RESP_OKAY, 32'h0});
		nq.push_back(3'h1);
		u_sgsel_partner.press(0);
		wait_nv();
		expect_out(2'h1, 8'h01);
		nq.push_back(3'h2);
		u_sgsel_partner.word(3'h2);
		wait_nv();
		axi(1'b1, `SGSEL_REG_CTRL, 32'h33, {`SGSEL_RESP_OKAY, 32'h0});
		u_sgsel_partner.press(0);
		u_sgsel_partner.word(3'h1);
		repeat (4) @(posedge clk);
		expect_out(2'h2, 8'h07);
		expect_out(2'h1, 8'h02);
		// second reset: the store keeps position two, alarms clear
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		expect_out(2'h1, 8'h02);
		expect_out(2'h2, 8'h00);
		results();
	end
endmodule
